/* File: src/display_timing_stage1_calc.sv */
// first-stage display timing calculator from a vertical or horizontal rate
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - line pixels rounded to whole cell multiples
// - field lines halved when interlaced, then rounded
// - vertical mode field rate doubles when interlaced
// - top and bottom margins from percent, else zero
// - interlace term is half line or zero
// - estimate line period from field period budget
// - sync plus back porch from estimated period
// - back porch is sync-plus-porch minus sync
// - total field lines sum all parts
// - estimate field rate, then correct line period
// - actual field rate per selected mode
// - frame rate halves field rate when interlaced
// - left and right margins in whole cells
// - active pixels include both side margins
// - blanking duty from offset and gradient
// - blank pixels rounded to double cells
// - total pixels equal active plus blank
// - pixel clock from total pixels per mode
// - line frequency and period per mode
// - horizontal mode sync-plus-porch from line frequency
// - every rounding goes to nearest integer
module display_timing_stage1_calc
  import timing_calc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // request, fractional values in 16-fraction-bit fixed point
  input wire logic i_start,
  input wire logic i_mode_horizontal,
  input wire logic i_interlace_request,
  input wire logic i_margin_request,
  input wire logic [VAL_W-1:0] i_line_pixels,
  input wire logic [VAL_W-1:0] i_field_lines,
  input wire logic [VAL_W-1:0] i_input_frequency,
  input wire logic [VAL_W-1:0] i_margin_percent,
  input wire logic [VAL_W-1:0] i_time_a,
  input wire logic [VAL_W-1:0] i_blank_offset_c,
  input wire logic [VAL_W-1:0] i_blank_gradient_m,
  input wire logic [7:0] i_cell_granularity,
  input wire logic [7:0] i_min_porch_lines,
  input wire logic [7:0] i_vertical_sync_width_lines,
  // status
  output logic o_busy,
  output logic o_done,
  // results
  output logic [VAL_W-1:0] o_rounded_line_pixels,
  output logic [VAL_W-1:0] o_rounded_field_lines,
  output logic [VAL_W-1:0] o_top_margin_lines,
  output logic [VAL_W-1:0] o_bottom_margin_lines,
  output logic [VAL_W-1:0] o_left_margin_pixels,
  output logic [VAL_W-1:0] o_right_margin_pixels,
  output logic [VAL_W-1:0] o_active_pixels,
  output logic [VAL_W-1:0] o_sync_plus_back_porch_lines,
  output logic [VAL_W-1:0] o_back_porch_lines,
  output logic [VAL_W-1:0] o_total_lines,
  output logic [VAL_W-1:0] o_blank_pixels,
  output logic [VAL_W-1:0] o_total_pixels,
  output logic [VAL_W-1:0] o_field_rate,
  output logic [VAL_W-1:0] o_frame_rate,
  output logic [VAL_W-1:0] o_line_period,
  output logic [VAL_W-1:0] o_line_frequency,
  output logic [VAL_W-1:0] o_pixel_clock_rate
);
  // ==========================================================================
  // arithmetic helpers
  function automatic logic [VAL_W-1:0] rnd(input logic [VAL_W-1:0] x);
    rnd = (x + HALF_Q) & INT_MASK_Q;
  endfunction

  function automatic logic [VAL_W-1:0] fmul(input logic [VAL_W-1:0] a, input logic [VAL_W-1:0] b);
    logic [2*VAL_W-1:0] p;
    p = a * b;
    fmul = p[VAL_W+FRAC_W-1:FRAC_W];
  endfunction

  function automatic logic [VAL_W-1:0] to_q(input logic [7:0] n);
    to_q = {24'h000000, n, 16'h0000};
  endfunction

  // ==========================================================================
  // request and working registers
  calc_state_t state_reg;
  calc_state_t state_next;
  logic wait_reg;
  logic div_start_reg;
  logic div_done;
  logic [VAL_W-1:0] div_quot;
  logic [VAL_W-1:0] op_a;
  logic [VAL_W-1:0] op_b;
  logic mode_h_reg, ilace_reg, margin_reg;
  logic [VAL_W-1:0] pix_in_reg, pct_reg, time_a_reg, c_off_reg, m_grad_reg;
  logic [VAL_W-1:0] cell_q_reg, porch_q_reg, vsync_q_reg;
  logic [VAL_W-1:0] field_rqd_reg, ilace_term_reg, lines_reg;
  logic [VAL_W-1:0] line_px_reg, top_reg, lmarg_reg, tmp_reg, est_reg;
  logic [VAL_W-1:0] sbp_reg, hp_reg, hfreq_reg, field_reg, duty_reg, blank_reg, pclk_reg;
  logic [VAL_W-1:0] total_lines, active_px, total_px, cell2_q;

  assign cell2_q = {cell_q_reg[VAL_W-2:0], 1'b0};
  assign total_lines = lines_reg + top_reg + top_reg + sbp_reg + ilace_term_reg + porch_q_reg;
  assign active_px = line_px_reg + lmarg_reg + lmarg_reg;
  assign total_px = active_px + blank_reg;

  // ==========================================================================
  // operands for each division step
  always_comb
  begin
    op_a = ZERO_Q;
    op_b = HUNDRED_Q;
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: state_next = S_IDLE;
      S_CELL:
      begin
        op_a = pix_in_reg;
        op_b = cell_q_reg;
        state_next = S_PCT;
      end
      S_PCT:
      begin
        // multiply before dividing so truncation stays far below the rounding step
        op_a = fmul(pct_reg, lines_reg);
        state_next = S_LMARG;
      end
      S_LMARG:
      begin
        op_a = fmul(line_px_reg, pct_reg);
        op_b = fmul(cell_q_reg, HUNDRED_Q);
        state_next = mode_h_reg ? S_HPER : S_VINV;
      end
      S_VINV:
      begin
        op_a = MILLION_Q;
        op_b = field_rqd_reg;
        state_next = S_VEST;
      end
      S_VEST:
      begin
        op_a = tmp_reg - time_a_reg;
        op_b = lines_reg + {top_reg[VAL_W-2:0], 1'b0} + porch_q_reg + ilace_term_reg;
        state_next = S_VSBP;
      end
      S_VSBP:
      begin
        op_a = time_a_reg;
        op_b = est_reg;
        state_next = S_VFEST;
      end
      S_VFEST:
      begin
        op_a = MILLION_Q;
        op_b = fmul(est_reg, total_lines);
        state_next = S_VPER;
      end
      S_VPER:
      begin
        op_a = fmul(est_reg, tmp_reg);
        op_b = field_rqd_reg;
        state_next = S_VFIELD;
      end
      S_VFIELD:
      begin
        op_a = MILLION_Q;
        op_b = fmul(hp_reg, total_lines);
        state_next = S_VHFREQ;
      end
      S_VHFREQ:
      begin
        op_a = THOUSAND_Q;
        op_b = hp_reg;
        state_next = S_VDUTY;
      end
      S_VDUTY:
      begin
        op_a = fmul(m_grad_reg, hp_reg);
        op_b = THOUSAND_Q;
        state_next = S_BLANK1;
      end
      S_HPER:
      begin
        op_a = THOUSAND_Q;
        op_b = hfreq_reg;
        state_next = S_HSBP;
      end
      S_HSBP:
      begin
        op_a = fmul(time_a_reg, hfreq_reg);
        op_b = THOUSAND_Q;
        state_next = S_HFIELD;
      end
      S_HFIELD:
      begin
        op_a = fmul(hfreq_reg, THOUSAND_Q);
        op_b = total_lines;
        state_next = S_HDUTY;
      end
      S_HDUTY:
      begin
        op_a = m_grad_reg;
        op_b = hfreq_reg;
        state_next = S_BLANK1;
      end
      S_BLANK1:
      begin
        op_a = fmul(active_px, duty_reg);
        op_b = HUNDRED_Q - duty_reg;
        state_next = S_BLANK2;
      end
      S_BLANK2:
      begin
        op_a = tmp_reg;
        op_b = cell2_q;
        state_next = S_PCLK;
      end
      S_PCLK:
      begin
        op_a = mode_h_reg ? fmul(total_px, hfreq_reg) : total_px;
        op_b = mode_h_reg ? THOUSAND_Q : hp_reg;
        state_next = S_FINISH;
      end
      S_FINISH: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ==========================================================================
  // sequencing: launch one division per step, advance on its completion
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= S_IDLE;
      wait_reg <= 1'b0;
      div_start_reg <= 1'b0;
    end
    else
    begin
      div_start_reg <= 1'b0;
      if (state_reg == S_IDLE)
      begin
        if (i_start)
          state_reg <= S_CELL;
      end
      else if (state_reg == S_FINISH)
        state_reg <= S_IDLE;
      else if (!wait_reg)
      begin
        wait_reg <= 1'b1;
        div_start_reg <= 1'b1;
      end
      else if (div_done)
      begin
        wait_reg <= 1'b0;
        state_reg <= state_next;
      end
    end
  end

  fixq_divider u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(div_start_reg),
    .i_num(op_a),
    .i_den(op_b),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // ==========================================================================
  // request capture; inputs may change freely once the request is taken
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {mode_h_reg, ilace_reg, margin_reg} <= 3'b000;
      {pix_in_reg, pct_reg, time_a_reg, c_off_reg, m_grad_reg} <= '0;
      {cell_q_reg, porch_q_reg, vsync_q_reg} <= '0;
      {field_rqd_reg, ilace_term_reg, lines_reg} <= '0;
    end
    else if (state_reg == S_IDLE && i_start)
    begin
      mode_h_reg <= i_mode_horizontal;
      ilace_reg <= i_interlace_request;
      margin_reg <= i_margin_request;
      pix_in_reg <= i_line_pixels;
      pct_reg <= i_margin_percent;
      time_a_reg <= i_time_a;
      c_off_reg <= i_blank_offset_c;
      m_grad_reg <= i_blank_gradient_m;
      cell_q_reg <= to_q(i_cell_granularity);
      porch_q_reg <= to_q(i_min_porch_lines);
      vsync_q_reg <= to_q(i_vertical_sync_width_lines);
      field_rqd_reg <= i_interlace_request ? {i_input_frequency[VAL_W-2:0], 1'b0} : i_input_frequency;
      ilace_term_reg <= i_interlace_request ? HALF_Q : ZERO_Q;
      lines_reg <= i_interlace_request ? rnd({1'b0, i_field_lines[VAL_W-1:1]}) : rnd(i_field_lines);
    end
  end

  // ==========================================================================
  // step results, all kept with fraction bits so rounding sees them
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {line_px_reg, top_reg, lmarg_reg, tmp_reg, est_reg} <= '0;
      {sbp_reg, hp_reg, hfreq_reg, field_reg, duty_reg, blank_reg, pclk_reg} <= '0;
    end
    else if (state_reg == S_IDLE && i_start)
      hfreq_reg <= i_input_frequency;
    else if (wait_reg && div_done)
    begin
      unique case (state_reg)
        S_CELL: line_px_reg <= fmul(rnd(div_quot), cell_q_reg);
        S_PCT: top_reg <= margin_reg ? rnd(div_quot) : ZERO_Q;
        S_LMARG: lmarg_reg <= margin_reg ? fmul(rnd(div_quot), cell_q_reg) : ZERO_Q;
        S_VINV: tmp_reg <= div_quot;
        S_VEST: est_reg <= div_quot;
        S_VSBP: sbp_reg <= rnd(div_quot);
        S_VFEST: tmp_reg <= div_quot;
        S_VPER: hp_reg <= div_quot;
        S_VFIELD: field_reg <= div_quot;
        S_VHFREQ: hfreq_reg <= div_quot;
        S_VDUTY: duty_reg <= c_off_reg - div_quot;
        S_HPER: hp_reg <= div_quot;
        S_HSBP: sbp_reg <= rnd(div_quot);
        S_HFIELD: field_reg <= div_quot;
        S_HDUTY: duty_reg <= c_off_reg - div_quot;
        S_BLANK1: tmp_reg <= div_quot;
        S_BLANK2: blank_reg <= fmul(rnd(div_quot), cell2_q);
        S_PCLK: pclk_reg <= div_quot;
        default: tmp_reg <= tmp_reg;
      endcase
    end
  end

  // ==========================================================================
  // result registers change only at the end of a request
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      {o_rounded_line_pixels, o_rounded_field_lines, o_top_margin_lines, o_bottom_margin_lines} <= '0;
      {o_left_margin_pixels, o_right_margin_pixels, o_active_pixels, o_sync_plus_back_porch_lines} <= '0;
      {o_back_porch_lines, o_total_lines, o_blank_pixels, o_total_pixels, o_field_rate} <= '0;
      {o_frame_rate, o_line_period, o_line_frequency, o_pixel_clock_rate} <= '0;
    end
    else
    begin
      o_done <= (state_reg == S_FINISH);
      if (state_reg == S_IDLE && i_start)
        o_busy <= 1'b1;
      else if (state_reg == S_FINISH)
      begin
        o_busy <= 1'b0;
        o_rounded_line_pixels <= line_px_reg;
        o_rounded_field_lines <= lines_reg;
        o_top_margin_lines <= top_reg;
        o_bottom_margin_lines <= top_reg;
        o_left_margin_pixels <= lmarg_reg;
        o_right_margin_pixels <= lmarg_reg;
        o_active_pixels <= active_px;
        o_sync_plus_back_porch_lines <= sbp_reg;
        o_back_porch_lines <= sbp_reg - vsync_q_reg;
        o_total_lines <= total_lines;
        o_blank_pixels <= blank_reg;
        o_total_pixels <= total_px;
        o_field_rate <= field_reg;
        o_frame_rate <= ilace_reg ? {1'b0, field_reg[VAL_W-1:1]} : field_reg;
        o_line_period <= hp_reg;
        o_line_frequency <= hfreq_reg;
        o_pixel_clock_rate <= pclk_reg;
      end
    end
  end

  // ==========================================================================
  // checks
  logic [11:0] lat_cnt_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lat_cnt_reg <= '0;
    else if (!o_busy)
      lat_cnt_reg <= '0;
    else
      lat_cnt_reg <= lat_cnt_reg + 12'h001;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence req_s;
    state_reg == S_IDLE && i_start;
  endsequence

  sequence fin_s;
    o_done && !o_busy;
  endsequence

  req_busy_a: assert property (req_s |=> o_busy ##1 o_busy) else $error("busy not raised by request");
  latency_a: assert property (lat_cnt_reg <= LAT_MAX) else $error("request took too long");
  done_pulse_a: assert property (fin_s |=> !o_done) else $error("done longer than one cycle");
  hold_stable_a: assert property (!o_busy && !$past(o_busy) |-> $stable(o_total_pixels) && $stable(o_field_rate))
    else $error("results moved while idle");
  frame_rate_a: assert property (o_done |-> o_frame_rate == (ilace_reg ? o_field_rate >> 1 : o_field_rate))
    else $error("frame rate wrong");
  margin_pair_a: assert property (o_done |-> o_top_margin_lines == o_bottom_margin_lines
    && o_left_margin_pixels == o_right_margin_pixels
    && (margin_reg || (o_top_margin_lines == ZERO_Q && o_left_margin_pixels == ZERO_Q)))
    else $error("margins inconsistent");
  active_sum_a: assert property (o_done |-> o_active_pixels
    == o_rounded_line_pixels + o_left_margin_pixels + o_right_margin_pixels) else $error("active sum wrong");
  total_pix_a: assert property (o_done |-> o_total_pixels == o_active_pixels + o_blank_pixels)
    else $error("total pixels wrong");
  back_porch_a: assert property (o_done |-> o_back_porch_lines + vsync_q_reg == o_sync_plus_back_porch_lines)
    else $error("back porch wrong");
  total_lines_a: assert property (o_done |-> o_total_lines == o_rounded_field_lines + o_top_margin_lines
    + o_bottom_margin_lines + o_sync_plus_back_porch_lines + ilace_term_reg + porch_q_reg)
    else $error("total lines wrong");
endmodule
`default_nettype wire

/* File: src/timing_calc_pkg.sv */
// shared constants for the first-stage display timing calculator
package timing_calc_pkg;
  // ==========================================================================
  // fixed-point format: unsigned, 16 fraction bits
  localparam int VAL_W = 48;
  localparam int FRAC_W = 16;
  localparam int DIVN_W = VAL_W + FRAC_W;
  localparam logic [VAL_W-1:0] HALF_Q = 48'h000000008000;
  localparam logic [VAL_W-1:0] INT_MASK_Q = 48'hFFFFFFFF0000;
  localparam logic [VAL_W-1:0] HUNDRED_Q = 48'h000000640000;
  localparam logic [VAL_W-1:0] THOUSAND_Q = 48'h000003E80000;
  localparam logic [VAL_W-1:0] MILLION_Q = 48'h000F42400000;
  localparam logic [VAL_W-1:0] ZERO_Q = 48'h000000000000;
  // ==========================================================================
  // timing of the shared divider and of a whole request
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam int LAT_MAX = 1100;
  // ==========================================================================
  // calculation sequence
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00000,
    S_CELL   = 5'b00001,
    S_PCT    = 5'b00010,
    S_LMARG  = 5'b00011,
    S_VINV   = 5'b00100,
    S_VEST   = 5'b00101,
    S_VSBP   = 5'b00110,
    S_VFEST  = 5'b00111,
    S_VPER   = 5'b01000,
    S_VFIELD = 5'b01001,
    S_VHFREQ = 5'b01010,
    S_VDUTY  = 5'b01011,
    S_HPER   = 5'b01100,
    S_HSBP   = 5'b01101,
    S_HFIELD = 5'b01110,
    S_HDUTY  = 5'b01111,
    S_BLANK1 = 5'b10000,
    S_BLANK2 = 5'b10001,
    S_PCLK   = 5'b10010,
    S_FINISH = 5'b10011
  } calc_state_t;
endpackage

/* File: src/fixq_divider.sv */
// sequential restoring divider returning a/b in the shared fixed-point format
`timescale 1ns/1ps
`default_nettype none
module fixq_divider
  import timing_calc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // operands
  input wire logic i_start,
  input wire logic [VAL_W-1:0] i_num,
  input wire logic [VAL_W-1:0] i_den,
  // result
  output logic o_done,
  output logic [VAL_W-1:0] o_quot
);
  // ==========================================================================
  // shift datapath
  logic [DIVN_W-1:0] shf_reg;
  logic [VAL_W:0] rem_reg;
  logic [VAL_W-1:0] den_reg;
  logic [6:0] cnt_reg;
  logic [VAL_W:0] trial;

  // one quotient bit a cycle keeps area small; a request takes many divisions
  assign trial = {rem_reg[VAL_W-1:0], shf_reg[DIVN_W-1]};
  assign o_quot = shf_reg[VAL_W-1:0];

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      shf_reg <= '0;
      rem_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      o_done <= 1'b0;
    end
    else if (i_start)
    begin
      shf_reg <= {i_num, 16'h0000};
      rem_reg <= '0;
      den_reg <= i_den;
      cnt_reg <= DIV_STEPS;
      o_done <= 1'b0;
    end
    else if (cnt_reg != 7'h00)
    begin
      if (trial >= {1'b0, den_reg})
      begin
        rem_reg <= trial - {1'b0, den_reg};
        shf_reg <= {shf_reg[DIVN_W-2:0], 1'b1};
      end
      else
      begin
        rem_reg <= trial;
        shf_reg <= {shf_reg[DIVN_W-2:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 7'h01;
      o_done <= (cnt_reg == 7'h01);
    end
    else
    begin
      o_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/request_source.sv */
// configuration source model handing one timing request at a time to the calculator
`timescale 1ns/1ps
`default_nettype none
module request_source
  import timing_calc_pkg::*;
(
  // clock and status
  input wire logic i_clk_sys,
  input wire logic i_busy,
  // request
  output logic o_start,
  output logic o_mode_horizontal,
  output logic o_interlace_request,
  output logic o_margin_request,
  output logic [VAL_W-1:0] o_line_pixels,
  output logic [VAL_W-1:0] o_field_lines,
  output logic [VAL_W-1:0] o_input_frequency,
  output logic [VAL_W-1:0] o_margin_percent,
  output logic [VAL_W-1:0] o_time_a,
  output logic [VAL_W-1:0] o_blank_offset_c,
  output logic [VAL_W-1:0] o_blank_gradient_m,
  output logic [7:0] o_cell_granularity,
  output logic [7:0] o_min_porch_lines,
  output logic [7:0] o_vertical_sync_width_lines
);
  // ==========
  // request lines
  logic [3+7*VAL_W+23:0] req = '0;
  assign {o_mode_horizontal, o_interlace_request, o_margin_request, o_line_pixels, o_field_lines, o_input_frequency,
          o_margin_percent, o_time_a, o_blank_offset_c, o_blank_gradient_m, o_cell_granularity, o_min_porch_lines,
          o_vertical_sync_width_lines} = req;
  initial o_start = 1'b0;
  // ==========
  // called at a falling edge; early skips the idle wait to make a refused request
  task automatic send(input logic [3+7*VAL_W+23:0] r, input bit early);
    while (!early && i_busy !== 1'b0)
      @(negedge i_clk_sys);
    req = r;
    o_start = 1'b1;
    @(negedge i_clk_sys);
    o_start = 1'b0;
    // released lines show the inverse so a late sample shows up
    req = ~r;
  endtask
endmodule
`default_nettype wire

/* File: test/display_timing_stage1_calc_bench.sv */
// self-checking bench for the first-stage display timing calculator
`timescale 1ns/1ps
`default_nettype none
module display_timing_stage1_calc_bench
  import timing_calc_pkg::*;
;
  // ==========
  // signals
  localparam int LIMIT = 30000;
  localparam real TA = 550.0;
  localparam real CC = 30.0;
  localparam real MM = 300.0;
  logic i_clk_sys, i_rst_n, i_start, i_mode_horizontal, i_interlace_request, i_margin_request, o_busy, o_done;
  logic [VAL_W-1:0] i_line_pixels, i_field_lines, i_input_frequency, i_margin_percent;
  logic [VAL_W-1:0] i_time_a, i_blank_offset_c, i_blank_gradient_m;
  logic [7:0] i_cell_granularity, i_min_porch_lines, i_vertical_sync_width_lines;
  logic [VAL_W-1:0] got [17];
  logic [31:0] seed = 32'h3A52EAFD;
  string nm [17] = '{"lpx", "fln", "top", "bot", "lft", "rgt", "act", "sbp", "bp", "tln", "blk", "tpx",
                     "fhz", "frz", "per", "lkhz", "pclk"};
  real ex [17];
  bit fuzzy;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  display_timing_stage1_calc u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_mode_horizontal(i_mode_horizontal), .i_interlace_request(i_interlace_request),
    .i_margin_request(i_margin_request), .i_line_pixels(i_line_pixels), .i_field_lines(i_field_lines),
    .i_input_frequency(i_input_frequency), .i_margin_percent(i_margin_percent), .i_time_a(i_time_a),
    .i_blank_offset_c(i_blank_offset_c), .i_blank_gradient_m(i_blank_gradient_m),
    .i_cell_granularity(i_cell_granularity), .i_min_porch_lines(i_min_porch_lines),
    .i_vertical_sync_width_lines(i_vertical_sync_width_lines), .o_busy(o_busy), .o_done(o_done),
    .o_rounded_line_pixels(got[0]), .o_rounded_field_lines(got[1]),
    .o_top_margin_lines(got[2]), .o_bottom_margin_lines(got[3]), .o_left_margin_pixels(got[4]),
    .o_right_margin_pixels(got[5]), .o_active_pixels(got[6]), .o_sync_plus_back_porch_lines(got[7]),
    .o_back_porch_lines(got[8]), .o_total_lines(got[9]), .o_blank_pixels(got[10]), .o_total_pixels(got[11]),
    .o_field_rate(got[12]), .o_frame_rate(got[13]), .o_line_period(got[14]), .o_line_frequency(got[15]),
    .o_pixel_clock_rate(got[16]));
  request_source u_src (.i_clk_sys(i_clk_sys), .i_busy(o_busy), .o_start(i_start),
    .o_mode_horizontal(i_mode_horizontal), .o_interlace_request(i_interlace_request),
    .o_margin_request(i_margin_request), .o_line_pixels(i_line_pixels), .o_field_lines(i_field_lines),
    .o_input_frequency(i_input_frequency), .o_margin_percent(i_margin_percent), .o_time_a(i_time_a),
    .o_blank_offset_c(i_blank_offset_c), .o_blank_gradient_m(i_blank_gradient_m),
    .o_cell_granularity(i_cell_granularity), .o_min_porch_lines(i_min_porch_lines),
    .o_vertical_sync_width_lines(i_vertical_sync_width_lines));
  // ==========
  // helpers
  function automatic int unsigned nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [VAL_W-1:0] q(input real x);
    return VAL_W'(longint'(x * 65536.0));
  endfunction
  // draws too close to a half are redrawn, fixed-point rounding may go either way there
  function automatic real rnd(input real x);
    if (x - $floor(x) > 0.48 && x - $floor(x) < 0.52)
      fuzzy = 1'b1;
    return $floor(x + 0.5);
  endfunction
  task automatic note(input bit ok, input string what, input real e, input real g);
    n_tests++;
    if (!ok)
    begin
      bad_count++;
      $display("[ERR] %s expected %f seen %f", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // reference model in reals
  task automatic model(input bit hm, il, mg, input real px, ln, fq, pc, cg, mp, vs);
    real hp, est, ilt, duty;
    fuzzy = 1'b0;
    ex[0] = rnd(px / cg) * cg;
    ex[1] = il ? rnd(ln / 2) : rnd(ln);
    ex[2] = mg ? rnd(pc / 100 * ex[1]) : 0;
    ex[3] = ex[2];
    ex[4] = mg ? rnd(ex[0] * pc / 100 / cg) * cg : 0;
    ex[5] = ex[4];
    ex[6] = ex[0] + 2 * ex[4];
    ilt = il ? 0.5 : 0.0;
    if (hm)
    begin
      hp = 1000 / fq;
      ex[7] = rnd(TA * fq / 1000);
    end
    else
    begin
      est = (1 / (il ? 2 * fq : fq) - TA / 1.0e6) / (ex[1] + 2 * ex[2] + mp + ilt) * 1.0e6;
      ex[7] = rnd(TA / est);
    end
    ex[8] = ex[7] - vs;
    ex[9] = ex[1] + 2 * ex[2] + ex[7] + ilt + mp;
    if (!hm)
      hp = est * (1.0e6 / (est * ex[9])) / (il ? 2 * fq : fq);
    ex[14] = hp;
    ex[15] = hm ? fq : 1000 / hp;
    ex[12] = hm ? fq / ex[9] * 1000 : 1.0e6 / (hp * ex[9]);
    ex[13] = il ? ex[12] / 2 : ex[12];
    duty = hm ? CC - MM / fq : CC - MM * hp / 1000;
    ex[10] = rnd(ex[6] * duty / (100 - duty) / (2 * cg)) * 2 * cg;
    ex[11] = ex[6] + ex[10];
    ex[16] = hm ? ex[11] * fq / 1000 : ex[11] / hp;
  endtask
  task automatic check_all();
    real g, t;
    for (int k = 0; k < 17; k++)
    begin
      g = real'(got[k]) / 65536.0;
      t = (k < 12) ? 1.0e-9 : 2.0e-3 * ex[k] + 1.0e-3;
      note(!$isunknown(got[k]) && g - ex[k] <= t && ex[k] - g <= t, nm[k], ex[k], g);
    end
  endtask
  // ==========
  // one request, optionally with a start pulse while busy that must be ignored
  task automatic trial(input bit hm, il, mg, pk);
    real px, ln, fq, pc;
    int cg, mp, vs, n;
    do
    begin
      px = 600 + nxt() % 1400;
      ln = 400 + nxt() % 800;
      cg = 1 << (nxt() % 4);
      fq = (hm ? 30 + nxt() % 60 : 50 + nxt() % 40) + (nxt() % 256) / 256.0;
      pc = (nxt() % 512) / 64.0;
      mp = 1 + nxt() % 3;
      vs = 3 + nxt() % 5;
      model(hm, il, mg, px, ln, fq, pc, cg, mp, vs);
    end
    while (fuzzy);
    u_src.send({hm, il, mg, q(px), q(ln), q(fq), q(pc), q(TA), q(CC), q(MM), 8'(cg), 8'(mp), 8'(vs)}, 1'b0);
    note(o_busy === 1'b1, "busy", 1, o_busy);
    if (pk)
    begin
      repeat (100) @(negedge i_clk_sys);
      u_src.send({3'h0, q(px + 64), q(ln + 8), q(fq + 5), q(pc), q(TA), q(CC), q(MM), 8'h01, 8'h02, 8'h03}, 1'b1);
    end
    n = 0;
    while (o_done !== 1'b1 && n < LAT_MAX)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    note(o_done === 1'b1 && o_busy === 1'b0, "done", 1, o_done);
    check_all();
    if (pk)
    begin
      n = 0;
      repeat (LAT_MAX)
      begin
        @(negedge i_clk_sys);
        n += (o_done === 1'b1);
      end
      note(n == 0, "refused", 0, n);
      check_all();
    end
  endtask
  // ==========
  // clock, timeout and main sequence
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    int unsigned r;
    i_rst_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    for (int k = 0; k < 17; k++)
      note(got[k] === ZERO_Q, nm[k], 0.0, real'(got[k]) / 65536.0);
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    // every mode, interlace and margin combination, results back to back
    for (int k = 0; k < 8; k++)
      trial(k[2], k[1], k[0], k == 5);
    for (int k = 0; k < 4; k++)
    begin
      r = nxt();
      trial(r[0], r[1], r[2], 1'b0);
    end
    // reset in mid-request must clear held results and busy
    u_src.send({3'h1, q(800), q(600), q(60), q(0), q(TA), q(CC), q(MM), 8'h08, 8'h01, 8'h03}, 1'b0);
    repeat (50) @(negedge i_clk_sys);
    i_rst_n = 1'b0;
    @(negedge i_clk_sys);
    note(o_busy === 1'b0 && o_done === 1'b0, "busy", 0, o_busy);
    for (int k = 0; k < 17; k++)
      note(got[k] === ZERO_Q, nm[k], 0.0, real'(got[k]) / 65536.0);
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    trial(1'b0, 1'b1, 1'b1, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
